//--- meas_result_buffer.sv
// Measurement result buffer: tags converter results, queues them, and reads them back.
// Assumes a register master on the plain strobe port and one converter result strobe.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`include "meas_buf_params.svh"

module meas_result_buffer
	import meas_buf_pkg::*;
(
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	// Register port
	input  wire logic [`ADDR_W-1:0] reg_addr,
	input  wire logic [`DATA_W-1:0] reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [`DATA_W-1:0]      reg_rdata,
	// Converter side
	input  wire logic               scan_start,
	input  wire logic               conv_done,
	input  wire logic [`RES_W-1:0]  conv_result,
	// Per-input result path when buffer mode is off
	output logic                    direct_valid,
	output logic [`RES_W-1:0]       direct_result,
	output logic [1:0]              direct_src,
	// Converter may stall while the queue is full
	output logic                    conv_ready,
	// Interrupt
	output logic                    irq
);

	logic                rst_s1_r;
	logic                rst_s2_r;
	logic                rst_sync_n;
	logic [`DATA_W-1:0]  ctrl_r;
	logic [`IRQ_W-1:0]   irq_stat_r;
	logic [`IRQ_W-1:0]   irq_mask_r;
	logic [`DATA_W-1:0]  reg_rdata_r;
	logic                direct_valid_r;
	logic [`RES_W-1:0]   direct_result_r;
	logic [1:0]          direct_src_r;
	logic                buf_mode;
	scan_mode_e          scan_mode;
	src_e                cur_src;
	logic                scan_busy;
	logic                q_push;
	logic                q_ready;
	logic                q_pop;
	logic                q_valid;
	logic [`RES_W:0]     q_head;
	logic [`CNT_W-1:0]   q_level;
	logic                q_full;
	logic                empty_after_pop;
	logic [`IRQ_W-1:0]   irq_events;
	logic [`IRQ_W-1:0]   irq_w1c;

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	assign rst_sync_n = rst_s2_r;

	function automatic logic addr_hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] b);
		addr_hit = (a == b);
	endfunction : addr_hit

	// Tag is 1 for first_aux_input and temperature
	function automatic logic src_tag(input src_e s);
		src_tag = (s == SRC_FIRST_AUX_INPUT) || (s == SRC_TEMP);
	endfunction : src_tag

	assign buf_mode  = ctrl_r[`CTRL_BUF_MODE];
	assign scan_mode = scan_mode_e'(ctrl_r[`CTRL_SCAN_LO+1:`CTRL_SCAN_LO]);

	scan_order u_scan_order (
		.core_clk    (core_clk),
		.rst_n       (rst_sync_n),
		.scan_start  (scan_start),
		.scan_mode   (scan_mode),
		.single_first_aux_input (ctrl_r[`CTRL_FIRST_AUX_INPUT_SEL]),
		.auto_sel    (ctrl_r[`CTRL_TEMP_SEL:`CTRL_FIRST_AUX_INPUT_SEL]),
		.conv_done   (conv_done),
		.cur_src     (cur_src),
		.scan_busy   (scan_busy)
	);

	assign q_push = conv_done && buf_mode;
	assign q_pop  = reg_rd && addr_hit(reg_addr, `ADDR_BUF_WORD);
	assign conv_ready = !buf_mode || q_ready;

	result_queue u_result_queue (
		.core_clk   (core_clk),
		.rst_n      (rst_sync_n),
		.push       (q_push),
		.push_data  ({src_tag(cur_src), conv_result}),
		.push_ready (q_ready),
		.pop        (q_pop),
		.pop_valid  (q_valid),
		.head_data  (q_head),
		.level      (q_level)
	);

	assign q_full          = !q_ready;
	assign empty_after_pop = (q_level <= `CNT_W'(1));

	// Control register; writes to the buffer word fall through unused
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_r <= `CTRL_RESET;
		end else if (reg_wr && addr_hit(reg_addr, `ADDR_CTRL)) begin
			ctrl_r <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_mask_r <= `MASK_RESET;
		end else if (reg_wr && addr_hit(reg_addr, `ADDR_IRQ_MASK)) begin
			irq_mask_r <= reg_wdata[`IRQ_W-1:0];
		end
	end

	// Sticky events; a new event wins over a write-one clear
	assign irq_events[`IRQ_NOT_EMPTY] = q_push && q_ready;
	assign irq_events[`IRQ_FULL]      = q_push && !(q_pop && q_valid) && (q_level == `CNT_W'(`DEPTH-1));
	assign irq_events[`IRQ_OVERRUN]   = q_push && !q_ready;
	assign irq_w1c = (reg_wr && addr_hit(reg_addr, `ADDR_IRQ_STAT)) ?
		reg_wdata[`IRQ_W-1:0] : '0;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_w1c) | irq_events;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// Read data, one cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata_r <= 16'h4000;
		end else if (reg_rd) begin
			reg_rdata_r <= 16'h0000;
			case (reg_addr)
				`ADDR_BUF_WORD: begin
					reg_rdata_r[`BIT_FULL]  <= q_full;
					reg_rdata_r[`BIT_EMPTY] <= !q_valid || empty_after_pop;
					reg_rdata_r[`BIT_TAG]   <= q_valid ? q_head[`RES_W] : 1'b0;
					reg_rdata_r[`RES_W-1:0] <= q_valid ? q_head[`RES_W-1:0] : 12'h000;
				end
				`ADDR_CTRL: begin
					reg_rdata_r <= ctrl_r;
				end
				`ADDR_STATUS: begin
					reg_rdata_r[0] <= scan_busy;
					reg_rdata_r[1] <= !q_valid;
					reg_rdata_r[2] <= q_full;
				end
				`ADDR_IRQ_STAT: begin
					reg_rdata_r[`IRQ_W-1:0] <= irq_stat_r;
				end
				`ADDR_IRQ_MASK: begin
					reg_rdata_r[`IRQ_W-1:0] <= irq_mask_r;
				end
				`ADDR_LEVEL: begin
					reg_rdata_r[`CNT_W-1:0] <= q_level;
				end
				default: begin
					reg_rdata_r <= 16'h0000;
				end
			endcase
		end
	end
	assign reg_rdata = reg_rdata_r;

	// Per-input path, bypassing the buffer when buffer mode is off
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			direct_valid_r  <= 1'b0;
			direct_result_r <= 12'h000;
			direct_src_r    <= 2'h0;
		end else begin
			direct_valid_r <= conv_done && !buf_mode;
			if (conv_done && !buf_mode) begin
				direct_result_r <= conv_result;
				direct_src_r    <= cur_src;
			end
		end
	end
	assign direct_valid  = direct_valid_r;
	assign direct_result = direct_result_r;
	assign direct_src    = direct_src_r;

	property p_push_in_buf_mode;
		@(posedge core_clk) disable iff (!rst_sync_n)
		(conv_done && buf_mode && q_ready) |=> (q_level == $past(q_level) + `CNT_W'(1))
			|| $past(q_pop);
	endproperty
	a_push_in_buf_mode: assert property (p_push_in_buf_mode) else $error("result not queued");

	property p_no_direct_in_buf;
		@(posedge core_clk) disable iff (!rst_sync_n)
		(conv_done && buf_mode) |=> !direct_valid;
	endproperty
	a_no_direct_in_buf: assert property (p_no_direct_in_buf) else $error("direct path used");

	property p_full_flag;
		@(posedge core_clk) disable iff (!rst_sync_n)
		(q_pop && q_level == `CNT_W'(`DEPTH)) |=> reg_rdata[`BIT_FULL];
	endproperty
	a_full_flag: assert property (p_full_flag) else $error("full flag missing");

	property p_empty_flag;
		@(posedge core_clk) disable iff (!rst_sync_n)
		(q_pop && q_level == `CNT_W'(0)) |=> reg_rdata[`BIT_EMPTY];
	endproperty
	a_empty_flag: assert property (p_empty_flag) else $error("empty flag missing");

	property p_empty_on_last;
		@(posedge core_clk) disable iff (!rst_sync_n)
		(q_pop && q_level == `CNT_W'(1)) |=> reg_rdata[`BIT_EMPTY] && (!q_valid || $past(q_push));
	endproperty
	a_empty_on_last: assert property (p_empty_on_last) else $error("late empty flag");

	property p_not_empty;
		@(posedge core_clk) disable iff (!rst_sync_n)
		(q_pop && q_level > `CNT_W'(1)) |=> !reg_rdata[`BIT_EMPTY];
	endproperty
	a_not_empty: assert property (p_not_empty) else $error("false empty flag");

	property p_read_data;
		@(posedge core_clk) disable iff (!rst_sync_n)
		(q_pop && q_valid) |=> reg_rdata[`BIT_TAG:0] == $past(q_head);
	endproperty
	a_read_data: assert property (p_read_data) else $error("wrong head returned");

	property p_pop_drops;
		@(posedge core_clk) disable iff (!rst_sync_n)
		(q_pop && q_valid && !q_push) |=> q_level == $past(q_level) - `CNT_W'(1);
	endproperty
	a_pop_drops: assert property (p_pop_drops) else $error("entry not removed");

	property p_write_ignored;
		@(posedge core_clk) disable iff (!rst_sync_n)
		(reg_wr && addr_hit(reg_addr, `ADDR_BUF_WORD) && !q_push && !q_pop) |=> $stable(q_level);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("write changed buffer");

endmodule : meas_result_buffer

//--- meas_buf_params.svh
// Offsets, field positions, reset values and sizes of the measurement result buffer.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MEAS_BUF_PARAMS_SVH
`define MEAS_BUF_PARAMS_SVH

`define DEPTH            64
`define PTR_W            6
`define CNT_W            7
`define RES_W            12
`define ADDR_W           4
`define DATA_W           16

`define ADDR_BUF_WORD    4'h0
`define ADDR_CTRL        4'h1
`define ADDR_STATUS      4'h2
`define ADDR_IRQ_STAT    4'h3
`define ADDR_IRQ_MASK    4'h4
`define ADDR_LEVEL       4'h5

`define BIT_FULL         15
`define BIT_EMPTY        14
`define BIT_TAG          12

`define CTRL_BUF_MODE    0
`define CTRL_SCAN_LO     1
`define CTRL_FIRST_AUX_INPUT_SEL    3
`define CTRL_SECOND_AUX_INPUT_SEL    4
`define CTRL_TEMP_SEL    5

`define IRQ_NOT_EMPTY    0
`define IRQ_FULL         1
`define IRQ_OVERRUN      2
`define IRQ_W            3

`define CTRL_RESET       16'h0000
`define MASK_RESET       3'h0

`endif

//--- meas_buf_pkg.sv
// Types shared by the measurement result buffer modules.
// Assumes the constants header is on the include path.
`include "meas_buf_params.svh"

package meas_buf_pkg;

	typedef enum logic [1:0] {
		SRC_BATTERY  = 2'b00,
		SRC_FIRST_AUX_INPUT     = 2'b01,
		SRC_SECOND_AUX_INPUT     = 2'b10,
		SRC_TEMP     = 2'b11
	} src_e;

	typedef enum logic [1:0] {
		SCAN_SINGLE  = 2'b00,
		SCAN_AUTO    = 2'b01,
		SCAN_PORT    = 2'b10
	} scan_mode_e;

	typedef enum logic [1:0] {
		SEQ_IDLE     = 2'b00,
		SEQ_WAIT     = 2'b01,
		SEQ_NEXT     = 2'b10
	} seq_state_e;

	typedef logic [`RES_W-1:0] result_t;

endpackage : meas_buf_pkg

//--- scan_order.sv
// Scan sequencer: names which input the next converter result belongs to.
// Assumes conv_done pulses once per result and scan_start once per scan.
module scan_order
	import meas_buf_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Scan setup
	input  wire logic       scan_start,
	input  wire scan_mode_e scan_mode,
	input  wire logic       single_first_aux_input,
	input  wire logic [2:0] auto_sel,
	// Result strobe
	input  wire logic       conv_done,
	output src_e            cur_src,
	output logic            scan_busy
);

	seq_state_e state_r;
	src_e       src_r;
	logic [2:0] left_r;

	// First selected input in auto order: first_aux_input, second_aux_input, temp
	function automatic src_e first_auto(input logic [2:0] sel);
		if (sel[0]) begin
			first_auto = SRC_FIRST_AUX_INPUT;
		end else if (sel[1]) begin
			first_auto = SRC_SECOND_AUX_INPUT;
		end else begin
			first_auto = SRC_TEMP;
		end
	endfunction : first_auto

	assign cur_src   = src_r;
	assign scan_busy = (state_r != SEQ_IDLE);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= SEQ_IDLE;
			src_r   <= SRC_BATTERY;
			left_r  <= 3'h0;
		end else begin
			case (state_r)
				SEQ_IDLE: begin
					if (scan_start) begin
						state_r <= SEQ_WAIT;
						case (scan_mode)
							SCAN_AUTO: begin
								src_r  <= first_auto(auto_sel);
								left_r <= auto_sel;
							end
							SCAN_PORT: begin
								src_r  <= SRC_BATTERY;
								left_r <= 3'h7;
							end
							default: begin
								src_r  <= single_first_aux_input ? SRC_FIRST_AUX_INPUT : SRC_BATTERY;
								left_r <= 3'h0;
							end
						endcase
					end
				end
				SEQ_WAIT: begin
					if (conv_done) begin
						state_r <= SEQ_NEXT;
					end
				end
				SEQ_NEXT: begin
					state_r <= SEQ_IDLE;
					if (scan_mode == SCAN_PORT) begin
						if (src_r == SRC_BATTERY) begin
							src_r   <= SRC_FIRST_AUX_INPUT;
							state_r <= SEQ_WAIT;
						end else if (src_r == SRC_FIRST_AUX_INPUT) begin
							src_r   <= SRC_SECOND_AUX_INPUT;
							state_r <= SEQ_WAIT;
						end
					end else if (scan_mode == SCAN_AUTO) begin
						if (src_r == SRC_FIRST_AUX_INPUT && left_r[1]) begin
							src_r   <= SRC_SECOND_AUX_INPUT;
							state_r <= SEQ_WAIT;
						end else if (src_r != SRC_TEMP && left_r[2]) begin
							src_r   <= SRC_TEMP;
							state_r <= SEQ_WAIT;
						end
					end
				end
				default: begin
					state_r <= SEQ_IDLE;
				end
			endcase
		end
	end

endmodule : scan_order

//--- result_queue.sv
// Sixty-four entry queue of 13-bit tagged results in flip-flops.
// Assumes push and pop come from one clock domain; pop of empty is ignored.
`include "meas_buf_params.svh"

module result_queue
	import meas_buf_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// Fill side
	input  wire logic              push,
	input  wire logic [`RES_W:0]   push_data,
	output logic                   push_ready,
	// Drain side
	input  wire logic              pop,
	output logic                   pop_valid,
	output logic [`RES_W:0]        head_data,
	output logic [`CNT_W-1:0]      level
);

	logic [`RES_W:0]   mem_r [`DEPTH];
	logic [`PTR_W-1:0] wr_ptr_r;
	logic [`PTR_W-1:0] rd_ptr_r;
	logic [`CNT_W-1:0] cnt_r;
	logic              do_push;
	logic              do_pop;

	assign pop_valid  = (cnt_r != '0);
	assign push_ready = (cnt_r != `CNT_W'(`DEPTH));
	assign do_pop     = pop && pop_valid;
	assign do_push    = push && push_ready;
	assign head_data  = mem_r[rd_ptr_r];
	assign level      = cnt_r;

	always_ff @(posedge core_clk) begin
		if (do_push) begin
			mem_r[wr_ptr_r] <= push_data;
		end
	end

	// Reset discards every entry
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_r <= wr_ptr_r + `PTR_W'(1);
			end
			if (do_pop) begin
				rd_ptr_r <= rd_ptr_r + `PTR_W'(1);
			end
			case ({do_push, do_pop})
				2'b10:   cnt_r <= cnt_r + `CNT_W'(1);
				2'b01:   cnt_r <= cnt_r - `CNT_W'(1);
				default: cnt_r <= cnt_r;
			endcase
		end
	end

endmodule : result_queue

//--- test_meas_result_buffer.sv
// Self-checking bench for the measurement result buffer: register port, scans, queue, irq.
// Assumes the constants header, the package and the design modules are compiled before it.
`include "meas_buf_params.svh"

module test_meas_result_buffer
	import meas_buf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic               core_clk;
	logic               rst_n;
	logic [`ADDR_W-1:0] reg_addr;
	logic [`DATA_W-1:0] reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [`DATA_W-1:0] reg_rdata;
	logic               scan_start;
	logic               conv_done;
	logic [`RES_W-1:0]  conv_result;
	logic               direct_valid;
	logic [`RES_W-1:0]  direct_result;
	logic [1:0]         direct_src;
	logic               conv_ready;
	logic               irq;
	int                 num_errors;
	int                 total_checks;
	logic [`RES_W:0]    exp_q[$];
	logic [`RES_W-1:0]  corner[$];

	meas_result_buffer meas_result_buffer_i (
		.core_clk      (core_clk),
		.rst_n         (rst_n),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.scan_start    (scan_start),
		.conv_done     (conv_done),
		.conv_result   (conv_result),
		.direct_valid  (direct_valid),
		.direct_result (direct_result),
		.direct_src    (direct_src),
		.conv_ready    (conv_ready),
		.irq           (irq)
	);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		#1;
	endtask : wr

	// Read data are taken in the single cycle after the strobe
	task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1;
		chk(name, exp, reg_rdata);
	endtask : rd_chk

	task automatic conv(input logic [11:0] r);
		@(posedge core_clk);
		conv_done   <= 1'b1;
		conv_result <= r;
		@(posedge core_clk);
		conv_done   <= 1'b0;
		#1;
	endtask : conv

	task automatic start;
		@(posedge core_clk);
		scan_start <= 1'b1;
		@(posedge core_clk);
		scan_start <= 1'b0;
	endtask : start

	// Tags expected per scan: battery and second_aux_input give 0, first_aux_input and temperature give 1
	task automatic scan(input logic [1:0] mode, input logic [2:0] sel);
		logic        tags[$];
		logic [11:0] r;
		start();
		case (mode)
			2'h0: tags.push_back(sel[0]);
			2'h1: begin
				if (sel[0]) tags.push_back(1'b1);
				if (sel[1]) tags.push_back(1'b0);
				if (sel[2]) tags.push_back(1'b1);
			end
			default: tags = '{1'b0, 1'b1, 1'b0};
		endcase
		foreach (tags[i]) begin
			r = (corner.size() > 0) ? corner.pop_front() : 12'($urandom);
			conv(r);
			exp_q.push_back({tags[i], r});
		end
		repeat (2) @(posedge core_clk);
		#1;
	endtask : scan

	// Oldest first; full on a read at 64 held, empty on the read of the last entry
	task automatic drain(input string name);
		int              n;
		logic [`RES_W:0] e;
		n = exp_q.size();
		for (int i = 0; i < n; i++) begin
			e = exp_q.pop_front();
			rd_chk(name, `ADDR_BUF_WORD, {(i == 0 && n == `DEPTH), (i == n - 1), 1'b0, e});
		end
		rd_chk({name, " empty"}, `ADDR_BUF_WORD, 16'h4000);
		$display("test %s done", name);
	endtask : drain

	initial begin
		#500000;
		num_errors++;
		$display("watchdog expired");
		print_verdict();
	end

	initial begin
		rst_n        = 1'b0;
		reg_addr     = 4'h0;
		reg_wdata    = 16'h0000;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		scan_start   = 1'b0;
		conv_done    = 1'b0;
		conv_result  = 12'h000;
		num_errors   = 0;
		total_checks = 0;
		void'($urandom(54));
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd_chk("reset word", `ADDR_BUF_WORD, 16'h4000);
		chk("conv_ready reset", 16'h0001, {15'h0, conv_ready});
		rd_chk("status reset", `ADDR_STATUS, 16'h0002);
		wr(`ADDR_CTRL, 16'h0009);
		wr(`ADDR_BUF_WORD, 16'h1234);
		rd_chk("write ignored", `ADDR_BUF_WORD, 16'h4000);
		$display("test reset done");
		corner = '{12'hFFF, 12'h800, 12'h001, 12'h000};
		repeat (4) scan(2'h0, 3'h1);
		drain("single first_aux_input");
		wr(`ADDR_CTRL, 16'h0001);
		repeat (3) scan(2'h0, 3'h0);
		drain("single battery");
		for (int s = 1; s < 8; s++) begin
			wr(`ADDR_CTRL, 16'({s[2:0], 2'h1, 1'b1}));
			scan(2'h1, s[2:0]);
		end
		drain("auto scan");
		wr(`ADDR_CTRL, 16'h0005);
		repeat (2) scan(2'h2, 3'h0);
		drain("port scan");
		wr(`ADDR_CTRL, 16'h0001);
		wr(`ADDR_IRQ_STAT, 16'h0007);
		repeat (`DEPTH) scan(2'h0, 3'h0);
		chk("irq masked", 16'h0000, {15'h0, irq});
		chk("conv_ready full", 16'h0000, {15'h0, conv_ready});
		rd_chk("level full", `ADDR_LEVEL, 16'h0040);
		rd_chk("status full", `ADDR_STATUS, 16'h0004);
		scan(2'h0, 3'h0);
		void'(exp_q.pop_back());
		rd_chk("irq status", `ADDR_IRQ_STAT, 16'h0007);
		wr(`ADDR_IRQ_MASK, 16'h0004);
		chk("irq unmasked", 16'h0001, {15'h0, irq});
		rd_chk("irq mask", `ADDR_IRQ_MASK, 16'h0004);
		drain("full buffer");
		wr(`ADDR_IRQ_STAT, 16'h0007);
		chk("irq cleared", 16'h0000, {15'h0, irq});
		rd_chk("irq status clear", `ADDR_IRQ_STAT, 16'h0000);
		$display("test interrupt done");
		wr(`ADDR_CTRL, 16'h0008);
		start();
		conv(12'hABC);
		chk("direct_valid", 16'h0001, {15'h0, direct_valid});
		chk("direct_result", 16'h0ABC, {4'h0, direct_result});
		chk("direct_src", 16'h0001, {14'h0, direct_src});
		rd_chk("buffer bypassed", `ADDR_BUF_WORD, 16'h4000);
		rd_chk("unmapped", 4'hF, 16'h0000);
		$display("test buffer off done");
		wr(`ADDR_CTRL, 16'h0001);
		repeat (2) scan(2'h0, 3'h0);
		exp_q.delete();
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd_chk("reset discards", `ADDR_BUF_WORD, 16'h4000);
		rd_chk("ctrl after reset", `ADDR_CTRL, 16'h0000);
		$display("test mid reset done");
		print_verdict();
	end

endmodule : test_meas_result_buffer
